// ===== cds_defs.vh
// register indices, field positions and counts for the distribution sync block
`ifndef CDS_DEFS_VH
`define CDS_DEFS_VH
// register indices; byte address is four times the index
`define CDS_IDX_DIST_EN 12'h401
`define CDS_IDX_DIST_SYNC 12'h402
`define CDS_IDX_AUTO_SYNC 12'h403
`define CDS_IDX_TRIG 12'hA02
`define CDS_IDX_DIV_BASE 12'h500
`define CDS_IDX_PH_TGT 12'h30F
`define CDS_IDX_SLEW 12'h316
`define CDS_IDX_STATUS 12'hD03
// sync control fields
`define CDS_MASK_MSB 3
`define CDS_MASK_LSB 0
`define CDS_SRC_MSB 5
`define CDS_SRC_LSB 4
`define CDS_SRC_DIRECT 2'b00
`define CDS_SRC_REF 2'b01
`define CDS_SRC_FB 2'b10
// automatic sync fields
`define CDS_AUTO_FREQ 0
`define CDS_AUTO_PHASE 1
// trigger register: sync distribution bit
`define CDS_TRIG_SYNC 1
// status fields
`define CDS_ST_STALL 0
`define CDS_ST_ARMED 1
`define CDS_ST_DONE 3
// reset values
`define CDS_RST_BYTE 8'h00
`define CDS_RST_EN 4'hF
`define CDS_RST_DIV 30'h0000_0000
`define CDS_RST_PH 16'h0000
`define CDS_RST_SLEW 16'h0001
// divider input edges consumed by the reclocking stage
`define CDS_RECLK_EDGES 3'h4
`endif

// ===== cds_dist_sync.v
// clock distribution synchronization: triggers, restart paths, dividers
//
// Overview of operation
// [R1] primary sync is OR of four triggers
// [R2] multifunction pin falling edge is the event
// [R3] sync bit one-to-zero transition is the event
// [R4] auto trigger on selected frequency/phase lock
// [R5] source 00: primary falling edge restarts directly
// [R6] source 01: arm, next reference rise restarts
// [R7] source 10: arm, next feedback rollover restarts
// [R8] detector follows currently active reference
// [R9] armed detector output high stalls dividers
// [R10] first reference rise drops output, restarts
// [R11] restart reclocked into divider input clock
// [R12] one-time alignment, no continuous tracking
// [R13] masked channel ignores sync
// [R14] masked channels run while others stall
// [R15] software adjusts edge timing after sync
// [R16] software may disable outputs while adjusting
// [R17] software uses small open-loop phase steps
// [R18] slew limit caps phase offset change rate
// [R19] divide ratio is programmed value plus one
// [R20] enable changes only at divider period boundary
// [R21] source 11 reserved, no restart
// [R22] unmasked dividers restart on one strobe
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`include "cds_defs.vh"
module cds_dist_sync (
    input wire ref_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire divider_input_clock,
    input wire [3:0] ref_in,
    input wire [1:0] active_ref_sel,
    input wire dpll_fb_rollover,
    input wire freq_lock,
    input wire phase_lock,
    input wire eeprom_sync,
    input wire multifunction_pins,
    output wire [3:0] out_clk,
    output wire dist_stall,
    output wire [15:0] phase_offset
);
    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;
    localparam ST_RECLK = 2'b10;

    // index hit for a register, used by write and read decode
    function hit;
        input [11:0] idx;
        input [11:0] reg_idx;
        begin
            hit = (idx == reg_idx);
        end
    endfunction

    wire [11:0] idx = paddr[13:2];
    wire wr = psel & penable & pwrite;
    wire [11:0] div_base = `CDS_IDX_DIV_BASE;
    wire div_hit = (idx[11:2] == div_base[11:2]);
    wire mapped = hit(idx, `CDS_IDX_DIST_EN) | hit(idx, `CDS_IDX_DIST_SYNC)
        | hit(idx, `CDS_IDX_AUTO_SYNC) | hit(idx, `CDS_IDX_TRIG)
        | hit(idx, `CDS_IDX_PH_TGT) | hit(idx, `CDS_IDX_SLEW)
        | hit(idx, `CDS_IDX_STATUS) | div_hit;

    // zero wait states keep the slave simple; unmapped answers with error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    reg [7:0] sync_ctl_q;
    reg [7:0] auto_ctl_q;
    reg [7:0] trig_q;
    reg [3:0] en_q;
    reg [29:0] div_q [0:3];
    reg [15:0] ph_tgt_q;
    reg [15:0] slew_q;
    reg [15:0] ph_cur_q;
    reg [1:0] state_q;
    reg [2:0] edge_cnt_q;
    reg done_q;

    wire [3:0] mask = sync_ctl_q[`CDS_MASK_MSB:`CDS_MASK_LSB];
    wire [1:0] src = sync_ctl_q[`CDS_SRC_MSB:`CDS_SRC_LSB];

    // register writes
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_ctl_q <= `CDS_RST_BYTE;
            auto_ctl_q <= `CDS_RST_BYTE;
            trig_q <= `CDS_RST_BYTE;
            en_q <= `CDS_RST_EN;
            div_q[0] <= `CDS_RST_DIV;
            div_q[1] <= `CDS_RST_DIV;
            div_q[2] <= `CDS_RST_DIV;
            div_q[3] <= `CDS_RST_DIV;
            ph_tgt_q <= `CDS_RST_PH;
            slew_q <= `CDS_RST_SLEW;
        end else if (wr) begin
            if (hit(idx, `CDS_IDX_DIST_SYNC))
                sync_ctl_q <= pwdata[7:0];
            if (hit(idx, `CDS_IDX_AUTO_SYNC))
                auto_ctl_q <= pwdata[7:0];
            if (hit(idx, `CDS_IDX_TRIG))
                trig_q <= pwdata[7:0];
            if (hit(idx, `CDS_IDX_DIST_EN))
                en_q <= pwdata[3:0];
            if (div_hit)
                div_q[idx[1:0]] <= pwdata[29:0];
            if (hit(idx, `CDS_IDX_PH_TGT))
                ph_tgt_q <= pwdata[15:0];
            if (hit(idx, `CDS_IDX_SLEW))
                slew_q <= pwdata[15:0];
        end
    end

    // read mux; narrow registers sit in the low bits
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        if (hit(idx, `CDS_IDX_DIST_SYNC))
            rd_mux[7:0] = sync_ctl_q;
        if (hit(idx, `CDS_IDX_AUTO_SYNC))
            rd_mux[7:0] = auto_ctl_q;
        if (hit(idx, `CDS_IDX_TRIG))
            rd_mux[7:0] = trig_q;
        if (hit(idx, `CDS_IDX_DIST_EN))
            rd_mux[3:0] = en_q;
        if (div_hit)
            rd_mux[29:0] = div_q[idx[1:0]];
        if (hit(idx, `CDS_IDX_PH_TGT))
            rd_mux[15:0] = ph_tgt_q;
        if (hit(idx, `CDS_IDX_SLEW))
            rd_mux[15:0] = slew_q;
        if (hit(idx, `CDS_IDX_STATUS)) begin
            rd_mux[`CDS_ST_STALL] = (state_q != ST_IDLE);
            rd_mux[`CDS_ST_ARMED] = (state_q == ST_WAIT);
            rd_mux[`CDS_ST_DONE] = done_q;
        end
    end

    // read data caught in the setup phase, so it leaves a flip-flop
    // without costing a wait state; status is one cycle old
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (psel & ~penable)
            prdata <= rd_mux;
    end

    // pin synchronisers; first stage feeds only the second
    reg [1:0] clkin_sy_q;
    reg clkin_prev_q;
    reg [3:0] ref_s1_q;
    reg [3:0] ref_s2_q;
    reg ref_prev_q;
    reg [1:0] mf_sy_q;
    reg mf_prev_q;
    reg freq_prev_q;
    reg phase_prev_q;
    reg prim_q;
    wire primary;
    wire ref_act = ref_s2_q[active_ref_sel]; // [R8]
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkin_sy_q <= 2'b00;
            clkin_prev_q <= 1'b0;
            ref_s1_q <= 4'h0;
            ref_s2_q <= 4'h0;
            ref_prev_q <= 1'b0;
            mf_sy_q <= 2'b11;
            mf_prev_q <= 1'b1;
            freq_prev_q <= 1'b0;
            phase_prev_q <= 1'b0;
            prim_q <= 1'b0;
        end else begin
            clkin_sy_q <= {clkin_sy_q[0], divider_input_clock};
            clkin_prev_q <= clkin_sy_q[1];
            ref_s1_q <= ref_in;
            ref_s2_q <= ref_s1_q;
            ref_prev_q <= ref_act;
            mf_sy_q <= {mf_sy_q[0], multifunction_pins};
            mf_prev_q <= mf_sy_q[1];
            freq_prev_q <= freq_lock;
            phase_prev_q <= phase_lock;
            prim_q <= primary;
        end
    end

    wire clkin_rise = clkin_sy_q[1] & ~clkin_prev_q;
    wire ref_rise = ref_act & ~ref_prev_q;
    wire mf_fall = mf_prev_q & ~mf_sy_q[1]; // [R2]
    // lock rise yields a one-cycle trigger pulse
    wire auto_pulse = (auto_ctl_q[`CDS_AUTO_FREQ] & freq_lock & ~freq_prev_q)
        | (auto_ctl_q[`CDS_AUTO_PHASE] & phase_lock & ~phase_prev_q); // [R4]
    // the bit level is the primary: set raises it, clear is the event
    wire sync_bit = trig_q[`CDS_TRIG_SYNC]; // [R3]
    assign primary = sync_bit | auto_pulse | mf_fall | eeprom_sync; // [R1]
    wire prim_rise = primary & ~prim_q;
    wire prim_fall = prim_q & ~primary;

    // restart sequencer: arm, wait for the event, reclock, restart once
    reg [1:0] state_d;
    reg event_hit;
    always @* begin
        state_d = state_q;
        event_hit = 1'b0;
        case (src)
            `CDS_SRC_DIRECT: event_hit = prim_fall; // [R5]
            `CDS_SRC_REF: event_hit = ref_rise; // [R6] [R10]
            `CDS_SRC_FB: event_hit = dpll_fb_rollover; // [R7]
            default: event_hit = 1'b0; // [R21]
        endcase
        case (state_q)
            ST_IDLE: begin
                if (prim_rise && src != 2'b11)
                    state_d = ST_WAIT; // [R9]
            end
            ST_WAIT: begin
                if (src == 2'b11)
                    state_d = ST_IDLE; // [R21]
                else if (event_hit)
                    state_d = ST_RECLK;
            end
            ST_RECLK: begin
                if (clkin_rise && edge_cnt_q == `CDS_RECLK_EDGES - 3'h1)
                    state_d = ST_IDLE; // [R11]
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // one pass per arming; nothing tracks drift after the restart
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            edge_cnt_q <= 3'h0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d; // [R12]
            if (state_q != ST_RECLK)
                edge_cnt_q <= 3'h0;
            else if (clkin_rise)
                edge_cnt_q <= edge_cnt_q + 3'h1; // [R11]
            if (state_q == ST_RECLK && state_d == ST_IDLE)
                done_q <= 1'b1;
            else if (state_d == ST_WAIT)
                done_q <= 1'b0;
        end
    end

    assign dist_stall = (state_q != ST_IDLE); // [R9] [R22]

    // channel dividers
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_ch
            reg [29:0] cnt_q;
            reg on_q;
            reg out_q;
            wire [29:0] dv = div_q[i];
            wire held = dist_stall & ~mask[i]; // [R13] [R14]
            wire [29:0] half = {1'b0, dv[29:1]} + 30'h1;
            wire wave = (dv == 30'h0) ? clkin_sy_q[1] : (cnt_q < half);
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_q <= 30'h0;
                    on_q <= 1'b0;
                    out_q <= 1'b0;
                end else if (held) begin
                    cnt_q <= 30'h0; // [R22]
                    on_q <= en_q[i];
                    out_q <= 1'b0;
                end else begin
                    if (clkin_rise) begin
                        if (cnt_q == dv) begin
                            cnt_q <= 30'h0; // [R19]
                            on_q <= en_q[i]; // [R20]
                        end else begin
                            cnt_q <= cnt_q + 30'h1;
                        end
                    end
                    out_q <= on_q & wave;
                end
            end
            assign out_clk[i] = out_q;
        end
    endgenerate

    // phase offset walks to target by at most the slew limit per cycle
    wire [16:0] up = {1'b0, ph_tgt_q} - {1'b0, ph_cur_q};
    wire [16:0] dn = {1'b0, ph_cur_q} - {1'b0, ph_tgt_q};
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            ph_cur_q <= `CDS_RST_PH;
        else if (ph_tgt_q > ph_cur_q)
            ph_cur_q <= (up[15:0] > slew_q) ? ph_cur_q + slew_q
                : ph_tgt_q; // [R18]
        else if (ph_tgt_q < ph_cur_q)
            ph_cur_q <= (dn[15:0] > slew_q) ? ph_cur_q - slew_q
                : ph_tgt_q; // [R18]
    end
    assign phase_offset = ph_cur_q;
endmodule

// ===== cds_dist_sync_asserts.sv
// port checker for the distribution sync block
`timescale 1ns/10ps
module cds_dist_sync_asserts (
    input wire ref_clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [13:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire [3:0] out_clk,
    input wire dist_stall,
    input wire [15:0] phase_offset
);
    reg [7:0] ctl_q;
    reg [15:0] slew_q;
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire [11:0] idx = paddr[13:2];
    wire trig_wr = wr && idx == 12'ha02;
    // shadow copies so checks need no peek inside
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= 8'h00;
            slew_q <= 16'h0001;
        end else if (wr && idx == 12'h402) begin
            ctl_q <= pwdata[7:0];
        end else if (wr && idx == 12'h316) begin
            slew_q <= pwdata[15:0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_mask_read: assert property (
        acc && !pwrite && idx == 12'h402 |-> prdata[7:0] == ctl_q)
        else $error("sync control readback differs");
    a_unmapped_err: assert property (
        acc && idx == 12'h123 |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_direct_arm: assert property (
        trig_wr && pwdata[1] && !dist_stall && ctl_q[5:4] != 2'b11
        |-> ##[1:3] dist_stall) else $error("sync bit did not arm");
    a_direct_fire: assert property (
        trig_wr && !pwdata[1] && dist_stall && ctl_q[5:4] == 2'b00
        |-> ##[1:60] !dist_stall) else $error("direct restart missing");
    a_reclock_min: assert property (
        $rose(dist_stall) |-> dist_stall[*8])
        else $error("restart faster than reclocking allows");
    a_stall_hold: assert property (
        dist_stall[*3] |-> (out_clk & ~ctl_q[3:0]) == 4'h0)
        else $error("unmasked channel runs while stalled");
    a_src_reserved: assert property (
        (ctl_q[5:4] == 2'b11)[*3] |-> !dist_stall)
        else $error("reserved source stalled");
    a_slew_cap: assert property (
        phase_offset - $past(phase_offset) <= slew_q ||
        $past(phase_offset) - phase_offset <= slew_q)
        else $error("phase step exceeds slew limit");
endmodule
bind cds_dist_sync cds_dist_sync_asserts cds_dist_sync_asserts_inst (.*);

// ===== cds_far_side.sv
// far-side sources: divider clock, references, feedback rollover
`timescale 1ns/10ps
module cds_far_side #(
    parameter GAP = 99
) (
    input wire ref_clk,
    output reg divider_input_clock,
    output reg [3:0] ref_in,
    output reg dpll_fb_rollover
);
    integer cnt = 0;
    // free clocks, unrelated to ref_clk so reclock phase varies
    initial begin
        divider_input_clock = 1'b0;
        forever #65 divider_input_clock = ~divider_input_clock;
    end
    // four references at distinct rates
    initial begin
        ref_in = 4'h0;
        forever #370 ref_in = ref_in + 4'h1;
    end
    // one-cycle rollover every GAP+1 cycles: a slow answer
    always @(posedge ref_clk) begin
        cnt <= (cnt >= GAP) ? 0 : cnt + 1;
        dpll_fb_rollover <= (cnt == GAP);
    end
endmodule

// ===== cds_dist_sync_tb_top.sv
// self-checking bench for the distribution sync block
`timescale 1ns/10ps
module cds_dist_sync_tb_top;
    reg ref_clk, rst_n, psel, penable, pwrite, err, x;
    reg freq_lock, phase_lock, eeprom_sync, multifunction_pins;
    reg [13:0] paddr;
    reg [31:0] pwdata, rd;
    reg [1:0] active_ref_sel;
    reg [3:0] acc4;
    wire [31:0] prdata;
    wire pready, pslverr, divider_input_clock, dpll_fb_rollover;
    wire dist_stall;
    wire [3:0] ref_in, out_clk;
    wire [15:0] phase_offset;
    integer failures, total_checks, n, k;
    cds_dist_sync cds_dist_sync_inst (.*);
    cds_far_side cds_far_side_inst (.*);
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task check(input [15:0] seen, input [15:0] exp, input [63:0] what);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("Error %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // one apb transfer; an idle edge first keeps psel single-driven
    task apb(input w, input [11:0] idx, input [15:0] d);
        begin
            @(posedge ref_clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= {idx, 2'b00};
            pwdata <= {16'h0000, d};
            @(posedge ref_clk);
            penable <= 1'b1;
            @(posedge ref_clk);
            while (pready !== 1'b1)
                @(posedge ref_clk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wait_stall(input v);
        begin
            n = 0;
            while (dist_stall !== v && n < 400) begin
                @(negedge ref_clk);
                n = n + 1;
            end
            check(dist_stall, v, "stall");
        end
    endtask
    // arm by one trigger kind, then clear it and await the restart
    task sync_run(input [1:0] src, input [1:0] kind, input [3:0] mask);
        begin
            apb(1, 12'h402, {8'h00, 2'b00, src, mask});
            case (kind)
            2'd0: apb(1, 12'ha02, 16'h0002);
            2'd1: begin
                // source 01 runs on phase lock, the others on frequency
                apb(1, 12'h403, {14'h0000, src[0], ~src[0]});
                if (src[0])
                    phase_lock <= 1'b1;
                else
                    freq_lock <= 1'b1;
            end
            2'd2: multifunction_pins <= 1'b0;
            default: eeprom_sync <= 1'b1;
            endcase
            wait_stall(1'b1);
            if (src == 2'b00) begin
                apb(0, 12'hd03, 16'h0000);
                check(rd[15:0], 16'h0003, "status");
                repeat (4) @(posedge ref_clk);
                acc4 = 4'h0;
                repeat (24) @(negedge ref_clk) acc4 = acc4 | out_clk;
                check(acc4, mask, "masked");
            end
            apb(1, 12'ha02, 16'h0000);
            freq_lock <= 1'b0;
            phase_lock <= 1'b0;
            multifunction_pins <= 1'b1;
            eeprom_sync <= 1'b0;
            apb(1, 12'h403, 16'h0000);
            wait_stall(1'b0);
            apb(0, 12'hd03, 16'h0000);
            check(rd[15:0], 16'h0008, "done");
            x = 1'b0;
            repeat (30) @(negedge ref_clk) x = x | (out_clk[0] ^ out_clk[1]);
            if (mask == 4'h0)
                check(x, 1'b0, "aligned");
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // watchdog, several times the expected run length
    initial begin
        #500000;
        failures = failures + 1;
        report_and_stop;
    end
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h0000_0000;
        freq_lock = 1'b0;
        phase_lock = 1'b0;
        eeprom_sync = 1'b0;
        multifunction_pins = 1'b1;
        active_ref_sel = 2'h1;
        failures = 0;
        total_checks = 0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(0, 12'h402, 16'h0000);
        check(rd[15:0], 16'h0000, "ctl");
        apb(0, 12'h316, 16'h0000);
        check(rd[15:0], 16'h0001, "slew");
        apb(1, 12'h123, 16'h0005);
        check(err, 1'b1, "unmapped");
        apb(0, 12'h123, 16'h0000);
        check(rd[15:0], 16'h0000, "unmapped");
        apb(1, 12'h500, 16'h0003);
        apb(1, 12'h501, 16'h0003);
        apb(1, 12'h502, 16'h0002);
        sync_run(2'b00, 2'd0, 4'h0);
        sync_run(2'b00, 2'd0, 4'h5);
        sync_run(2'b01, 2'd0, 4'h0);
        sync_run(2'b01, 2'd1, 4'h0);
        for (k = 0; k < 4; k = k + 1)
            sync_run(2'b10, k[1:0], 4'h0);
        apb(1, 12'h402, 16'h0030);
        apb(1, 12'ha02, 16'h0002);
        repeat (10) @(posedge ref_clk);
        check(dist_stall, 1'b0, "reserved");
        apb(1, 12'ha02, 16'h0000);
        // adjust only after the sync, outputs off meanwhile
        apb(1, 12'h401, 16'h0000);
        apb(1, 12'h316, 16'h0003);
        apb(1, 12'h30f, 16'h0040);
        // four edges after the target lands, at three per cycle
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        check(phase_offset, 16'h000c, "slewing");
        repeat (40) @(posedge ref_clk);
        check(phase_offset, 16'h0040, "phase");
        check(out_clk, 4'h0, "disabled");
        apb(1, 12'h401, 16'h000f);
        acc4 = 4'h0;
        repeat (30) @(negedge ref_clk) acc4 = acc4 | out_clk;
        check(acc4, 4'hf, "enabled");
        report_and_stop;
    end
endmodule
